// *** gdsr_top.sv ***
// Generator demand arbiter and demand status frame builder, Wishbone classic slave.
// Assumes decoded demand commands arrive as one-cycle strobes and the CAN
// transmitter takes a frame on frame_valid_o and frame_ready_i both high.
//
// What this block does
// - Broadcast status frame on change, 500/5000 ms bounds
// - Byte0 bits0-1: overall generator demand flag
// - Byte0 bits2-3: internal criterion demanding generator
// - Byte0 bits4-5: another network node demanding
// - Byte0 bits6-7: external activity or fault
// - Byte1 bits0-1: manual override detected
// - Byte1 bits2-3: unit inside quiet time
// - Byte1 bits4-5: quiet time being overridden
// - Bytes2-5: quiet window hours and minutes
// - Byte6: minimum run minutes, zero means none
// - External stop beats network and internal demand
// - External flag cleared by command or automatically
// - Track demanding nodes, run generator by demand
// - Own internal criteria add to network demand
//
// Chosen here: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
module gdsr_top #(
	parameter int CYC_PER_MS = gdsr_pkg::CYC_PER_MS,
	parameter int MS_PER_MIN = gdsr_pkg::MS_PER_MIN
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_we_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic cmd_valid_i,
	input wire logic [3:0] cmd_node_i,
	input wire logic cmd_demand_i,
	input wire logic cmd_qt_ovr_i,
	input wire logic cmd_ext_reset_i,
	input wire logic cmd_manual_i,
	input wire logic cmd_lock_i,
	input wire logic ext_activity_i,
	input wire logic gen_fault_i,
	output logic gen_run_o,
	output logic frame_valid_o,
	input wire logic frame_ready_i,
	output logic [28:0] frame_id_o,
	output logic [63:0] frame_data_o,
	output logic irq_o
);
	typedef struct packed {
		gdsr_pkg::gdsr_fr_t fr;
		logic fvalid;
		logic [15:0] list;
		logic manual;
		logic man_dem;
		logic lock;
		logic qt_ovr;
		logic ext;
		logic run;
		logic [7:0] run_min;
		logic [12:0] since_ms;
		logic [63:0] frame;
		logic [63:0] last;
		logic ack;
		logic [31:0] dat;
		logic [2:0] ctrl;
		logic [31:0] quiet;
		logic [7:0] minrun;
		logic [7:0] src;
		logic [2:0] irq_en;
		logic [28:0] id;
	} gdsr_state_t;

	gdsr_state_t s;
	gdsr_state_t next_s;
	logic ms_tick;
	logic min_tick;
	logic [gdsr_pkg::IRQ_W-1:0] irq_set;
	logic [gdsr_pkg::IRQ_W-1:0] irq_clr;
	logic [gdsr_pkg::IRQ_W-1:0] irq_stat;
	logic [63:0] cur;
	logic demand;
	logic stop;
	logic quiet_now;
	logic wr;

	// ==========================================================================
	// Helpers
	// ==========================================================================
	// Merge written bytes under the byte enables.
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nv,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[8*i +: 8] = nv[8*i +: 8];
			end
		end
		return r;
	endfunction : merge

	// Clamp a byte to its legal maximum.
	function automatic logic [7:0] sat(input logic [7:0] v, input logic [7:0] mx);
		return (v > mx) ? mx : v;
	endfunction : sat

	// Encode a condition as a two-bit flag field.
	function automatic logic [1:0] flag(input logic b);
		return b ? gdsr_pkg::FLAG_ON : gdsr_pkg::FLAG_OFF;
	endfunction : flag

	// ==========================================================================
	// Timebase and interrupts
	// ==========================================================================
	// Millisecond tick drives the broadcast bounds.
	gdsr_tick #(.N(CYC_PER_MS)) u_ms (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.en_i(1'b1),
		.clr_i(1'b0),
		.tick_o(ms_tick)
	);

	// Minute tick counts only while running and restarts at each start.
	gdsr_tick #(.N(MS_PER_MIN)) u_min (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.en_i(ms_tick & s.run),
		.clr_i(~s.run),
		.tick_o(min_tick)
	);

	gdsr_sticky #(.W(gdsr_pkg::IRQ_W)) u_irq (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.set_i(irq_set),
		.clr_i(irq_clr),
		.en_i(s.irq_en),
		.stat_o(irq_stat),
		.irq_o(irq_o)
	);

	// ==========================================================================
	// Arbitration and frame content
	// ==========================================================================
	// An external stop or a lock overrides every kind of demand.
	always_comb begin
		stop = s.ext | s.lock;
		quiet_now = s.ctrl[gdsr_pkg::CTRL_QUIET_BIT];
		if (s.manual) begin
			demand = s.man_dem & ~stop;
		end else begin
			demand = (s.ctrl[gdsr_pkg::CTRL_INT_BIT] | (|s.list)) & ~stop;
		end
		cur[7:0] = {flag(s.ext), flag(|s.list),
			flag(s.ctrl[gdsr_pkg::CTRL_INT_BIT]), flag(demand)};
		cur[15:8] = {flag(s.lock), flag(s.qt_ovr), flag(quiet_now), flag(s.manual)};
		cur[47:16] = s.quiet;
		cur[55:48] = s.minrun;
		cur[63:56] = gdsr_pkg::BYTE_FILL;
	end

	assign wr = wb_cyc_i & wb_stb_i & wb_we_i & s.ack;

	// Interrupt clear is a write-one-to-clear strobe on the clear register.
	always_comb begin
		irq_clr = '0;
		if (wr && wb_adr_i == gdsr_pkg::ADR_IRQ_CLR && wb_sel_i[0]) begin
			irq_clr = wb_dat_i[gdsr_pkg::IRQ_W-1:0];
		end
	end

	// ==========================================================================
	// Next state
	// ==========================================================================
	always_comb begin
		next_s = s;
		irq_set = '0;

		// Demand commands update the list and the latched command flags.
		if (cmd_valid_i) begin
			next_s.list[cmd_node_i] = cmd_demand_i;
			next_s.manual = cmd_manual_i;
			next_s.man_dem = cmd_demand_i;
			next_s.qt_ovr = cmd_qt_ovr_i;
			next_s.lock = cmd_lock_i;
		end

		// The external flag clears by command or automatically once the fault is
		// gone at a long broadcast bound; a new activity in the same cycle wins.
		// The long-bound launch restarts the count at once, so no tick is awaited here.
		if ((cmd_valid_i && cmd_ext_reset_i) || (s.ctrl[gdsr_pkg::CTRL_AUTOCLR_BIT]
			&& s.since_ms == gdsr_pkg::BCAST_MAX_CNT && !gen_fault_i)) begin
			next_s.ext = 1'b0;
		end
		if (ext_activity_i || gen_fault_i) begin
			next_s.ext = 1'b1;
			irq_set[gdsr_pkg::IRQ_EXT_BIT] = ~s.ext;
		end

		// Run while demanded outside quiet time, or until the minimum run expires.
		next_s.run = (demand & (~quiet_now | s.qt_ovr)) | (s.run & (s.run_min != 8'h00) & ~stop);
		if (!s.run && next_s.run) begin
			next_s.run_min = s.minrun;
		end else if (min_tick && s.run_min != 8'h00) begin
			next_s.run_min = s.run_min - 8'h01;
		end
		irq_set[gdsr_pkg::IRQ_RUN_BIT] = next_s.run ^ s.run;

		// Time since the last launch saturates at the long bound.
		if (ms_tick && s.since_ms != gdsr_pkg::BCAST_MAX_CNT) begin
			next_s.since_ms = s.since_ms + 13'h0001;
		end

		// Send on change no sooner than the short bound, and always at the long one.
		case (s.fr)
			gdsr_pkg::FR_IDLE: begin
				if ((cur != s.last && s.since_ms >= gdsr_pkg::BCAST_MIN_CNT)
					|| s.since_ms == gdsr_pkg::BCAST_MAX_CNT) begin
					next_s.frame = cur;
					next_s.id = {gdsr_pkg::PRIO_DEFAULT, 1'b0, gdsr_pkg::DGN_DEMAND_STATUS, s.src};
					next_s.fvalid = 1'b1;
					next_s.since_ms = '0;
					next_s.fr = gdsr_pkg::FR_SEND;
				end
			end
			gdsr_pkg::FR_SEND: begin
				if (frame_ready_i) begin
					next_s.last = s.frame;
					next_s.fvalid = 1'b0;
					next_s.fr = gdsr_pkg::FR_IDLE;
					irq_set[gdsr_pkg::IRQ_SENT_BIT] = 1'b1;
				end
			end
			default: begin
				next_s.fr = gdsr_pkg::FR_IDLE;
			end
		endcase

		// Wishbone: ack one cycle after the request, then drop for a cycle.
		next_s.ack = wb_cyc_i & wb_stb_i & ~s.ack;
		if (wb_cyc_i && wb_stb_i && !s.ack) begin
			if (wb_adr_i == gdsr_pkg::ADR_CTRL) begin
				next_s.dat = {29'h0, s.ctrl};
			end else if (wb_adr_i == gdsr_pkg::ADR_QUIET) begin
				next_s.dat = s.quiet;
			end else if (wb_adr_i == gdsr_pkg::ADR_MINRUN) begin
				next_s.dat = {24'h0, s.minrun};
			end else if (wb_adr_i == gdsr_pkg::ADR_STATUS) begin
				next_s.dat = {7'h0, s.run, 8'h0, cur[15:0]};
			end else if (wb_adr_i == gdsr_pkg::ADR_IRQ_STAT) begin
				next_s.dat = {29'h0, irq_stat};
			end else if (wb_adr_i == gdsr_pkg::ADR_IRQ_EN) begin
				next_s.dat = {29'h0, s.irq_en};
			end else if (wb_adr_i == gdsr_pkg::ADR_SRC) begin
				next_s.dat = {24'h0, s.src};
			end else if (wb_adr_i == gdsr_pkg::ADR_LIST) begin
				next_s.dat = {16'h0, s.list};
			end else begin
				next_s.dat = 32'h0;
			end
		end

		// Writes take effect on the acknowledged edge; quiet and minimum run bytes are clamped.
		if (wr) begin
			if (wb_adr_i == gdsr_pkg::ADR_CTRL) begin
				next_s.ctrl = 3'(merge({29'h0, s.ctrl}, wb_dat_i, wb_sel_i));
			end else if (wb_adr_i == gdsr_pkg::ADR_QUIET) begin
				next_s.quiet = merge(s.quiet, wb_dat_i, wb_sel_i);
				next_s.quiet[7:0] = sat(next_s.quiet[7:0], gdsr_pkg::HOUR_MAX);
				next_s.quiet[15:8] = sat(next_s.quiet[15:8], gdsr_pkg::MINUTE_MAX);
				next_s.quiet[23:16] = sat(next_s.quiet[23:16], gdsr_pkg::HOUR_MAX);
				next_s.quiet[31:24] = sat(next_s.quiet[31:24], gdsr_pkg::MINUTE_MAX);
			end else if (wb_adr_i == gdsr_pkg::ADR_MINRUN && wb_sel_i[0]) begin
				next_s.minrun = sat(wb_dat_i[7:0], gdsr_pkg::MINRUN_MAX);
			end else if (wb_adr_i == gdsr_pkg::ADR_IRQ_EN && wb_sel_i[0]) begin
				next_s.irq_en = wb_dat_i[gdsr_pkg::IRQ_W-1:0];
			end else if (wb_adr_i == gdsr_pkg::ADR_SRC && wb_sel_i[0]) begin
				next_s.src = wb_dat_i[7:0];
			end
		end
	end

	// ==========================================================================
	// State register
	// ==========================================================================
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s <= '0;
			s.src <= gdsr_pkg::SRC_ADDR_RST;
		end else begin
			s <= next_s;
		end
	end

	assign wb_dat_o = s.dat;
	assign wb_ack_o = s.ack;
	assign gen_run_o = s.run;
	assign frame_valid_o = s.fvalid;
	assign frame_id_o = s.id;
	assign frame_data_o = s.frame;

	// ==========================================================================
	// Assertions
	// ==========================================================================
	lock_no_run_a: assert property (@(posedge clk_i) disable iff (rst_i)
		s.lock |=> !gen_run_o)
		else $error("Generator runs while locked.");

	ext_stop_a: assert property (@(posedge clk_i) disable iff (rst_i)
		s.ext |=> !gen_run_o)
		else $error("Generator runs during an external stop.");

	frame_id_a: assert property (@(posedge clk_i) disable iff (rst_i)
		frame_valid_o |-> frame_id_o[28:8] == {3'h6, 1'b0, 17'h1FF80})
		else $error("Wrong identity on the status frame.");

	bcast_bound_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(frame_valid_o) |-> ($past(s.since_ms) >= 13'd500)
		&& (($past(s.frame) != $past(cur)) || ($past(s.last) != $past(cur))
		|| $past(s.since_ms) == 13'd5000))
		else $error("Status frame launched inside the short bound.");

	overall_dem_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(frame_valid_o) && !$past(s.manual) |-> frame_data_o[1:0] ==
		((frame_data_o[3:2] == 2'h1 || frame_data_o[5:4] == 2'h1)
		&& frame_data_o[7:6] == 2'h0 && frame_data_o[15:14] == 2'h0 ? 2'h1 : 2'h0))
		else $error("Overall demand field inconsistent.");

	internal_fld_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(frame_valid_o) |-> frame_data_o[3:2] == {1'b0, $past(s.ctrl[0])})
		else $error("Internal demand field wrong.");

	network_fld_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(frame_valid_o) |-> frame_data_o[5:4] == {1'b0, |$past(s.list)})
		else $error("Network demand field wrong.");

	node_track_a: assert property (@(posedge clk_i) disable iff (rst_i)
		cmd_valid_i |=> s.list[$past(cmd_node_i)] == $past(cmd_demand_i))
		else $error("Demand list not updated by a command.");

	ext_reset_a: assert property (@(posedge clk_i) disable iff (rst_i)
		cmd_valid_i && cmd_ext_reset_i && !ext_activity_i && !gen_fault_i |=> !s.ext)
		else $error("External flag not cleared by command.");

	min_run_a: assert property (@(posedge clk_i) disable iff (rst_i)
		s.run && s.run_min != 8'h00 && !s.ext && !s.lock |=> gen_run_o)
		else $error("Generator stopped before its minimum run.");

	wb_ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |=> !wb_ack_o)
		else $error("Acknowledge held longer than one cycle.");

endmodule : gdsr_top

// *** gdsr_pkg.sv ***
// Constants, register map and shared types of the generator demand status reporter.
// Assumes a 50 MHz system clock; this package depends on nothing outside itself.
package gdsr_pkg;

	// ==========================================================================
	// Timing
	// ==========================================================================
	localparam int CLK_HZ = 50_000_000;
	localparam int MS_PER_S = 1000;
	localparam int CYC_PER_MS = CLK_HZ / MS_PER_S;
	localparam int MS_PER_MIN = 60000;
	localparam int BCAST_MIN_MS = 500;
	localparam int BCAST_MAX_MS = 5000;
	localparam logic [12:0] BCAST_MIN_CNT = 13'(BCAST_MIN_MS);
	localparam logic [12:0] BCAST_MAX_CNT = 13'(BCAST_MAX_MS);

	// ==========================================================================
	// Message identity
	// ==========================================================================
	localparam logic [16:0] DGN_DEMAND_STATUS = 17'h1FF80;
	localparam logic [2:0] PRIO_DEFAULT = 3'h6;
	localparam logic [7:0] SRC_ADDR_RST = 8'h41;
	localparam logic [7:0] BYTE_FILL = 8'hFF;
	localparam logic [1:0] FLAG_ON = 2'h1;
	localparam logic [1:0] FLAG_OFF = 2'h0;

	// ==========================================================================
	// Register offsets (byte addresses)
	// ==========================================================================
	localparam logic [7:0] ADR_CTRL = 8'h00;
	localparam logic [7:0] ADR_QUIET = 8'h04;
	localparam logic [7:0] ADR_MINRUN = 8'h08;
	localparam logic [7:0] ADR_STATUS = 8'h0C;
	localparam logic [7:0] ADR_IRQ_STAT = 8'h10;
	localparam logic [7:0] ADR_IRQ_EN = 8'h14;
	localparam logic [7:0] ADR_IRQ_CLR = 8'h18;
	localparam logic [7:0] ADR_SRC = 8'h1C;
	localparam logic [7:0] ADR_LIST = 8'h20;

	// ==========================================================================
	// Field positions and limits
	// ==========================================================================
	localparam int CTRL_INT_BIT = 0;
	localparam int CTRL_QUIET_BIT = 1;
	localparam int CTRL_AUTOCLR_BIT = 2;
	localparam int STATUS_RUN_BIT = 24;
	localparam int IRQ_SENT_BIT = 0;
	localparam int IRQ_RUN_BIT = 1;
	localparam int IRQ_EXT_BIT = 2;
	localparam int IRQ_W = 3;
	localparam logic [7:0] HOUR_MAX = 8'h17;
	localparam logic [7:0] MINUTE_MAX = 8'h3B;
	localparam logic [7:0] MINRUN_MAX = 8'hFA;

	// Frame state machine.
	typedef enum logic {FR_IDLE, FR_SEND} gdsr_fr_t;

endpackage : gdsr_pkg

// *** gdsr_tick.sv ***
// Enabled cycle counter that emits a one-cycle pulse every N enabled cycles.
// Assumes a synchronous active-high reset and a clear that restarts the count.
`timescale 1ns/1ps
module gdsr_tick #(
	parameter int N = 4
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic en_i,
	input wire logic clr_i,
	output logic tick_o
);
	localparam int W = $clog2(N + 1);
	localparam logic [W-1:0] LAST = W'(N - 1);

	typedef struct packed {
		logic [W-1:0] cnt;
		logic tick;
	} gdsr_tick_st_t;

	gdsr_tick_st_t s;
	gdsr_tick_st_t next_s;

	// ==========================================================================
	// Counting
	// ==========================================================================
	// Count enabled cycles; the pulse is registered so it never glitches.
	always_comb begin
		next_s = s;
		next_s.tick = 1'b0;
		if (clr_i) begin
			next_s.cnt = '0;
		end else if (en_i) begin
			if (s.cnt == LAST) begin
				next_s.cnt = '0;
				next_s.tick = 1'b1;
			end else begin
				next_s.cnt = s.cnt + W'(1);
			end
		end
	end

	// Register the state.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign tick_o = s.tick;

endmodule : gdsr_tick

// *** gdsr_sticky.sv ***
// Sticky event flags with enable mask and one level interrupt.
// Assumes set and clear vectors come from the same clock domain.
`timescale 1ns/1ps
module gdsr_sticky #(
	parameter int W = 3
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [W-1:0] set_i,
	input wire logic [W-1:0] clr_i,
	input wire logic [W-1:0] en_i,
	output logic [W-1:0] stat_o,
	output logic irq_o
);
	typedef struct packed {
		logic [W-1:0] stat;
		logic irq;
	} gdsr_sticky_st_t;

	gdsr_sticky_st_t s;
	gdsr_sticky_st_t next_s;

	// ==========================================================================
	// Flags
	// ==========================================================================
	// A set in the same cycle as a clear wins, so no event is lost.
	always_comb begin
		next_s.stat = set_i | (s.stat & ~clr_i);
		next_s.irq = |(next_s.stat & en_i);
	end

	// Register the state.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign stat_o = s.stat;
	assign irq_o = s.irq;

	set_wins_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(|(set_i & clr_i)) |=> (|s.stat))
		else $error("Set lost against a clear.");

endmodule : gdsr_sticky

// *** gdsr_node_model.sv ***
// Far-side network nodes: demand command sender and status frame receiver.
// Assumes the reporter's clock; frames are taken after a chosen stall.
`timescale 1ns/1ps
module gdsr_node_model (
	input wire logic clk_i,
	input wire logic frame_valid_i,
	input wire logic [63:0] frame_data_i,
	input wire logic [28:0] frame_id_i,
	output logic frame_ready_o,
	output logic cmd_valid_o,
	output logic [3:0] cmd_node_o,
	output logic [4:0] cmd_flags_o
);
	// ==========================================================================
	// Receiver state
	// ==========================================================================
	int cyc = 0;
	int ready_wait = 0;
	int wait_cnt = 0;
	logic valid_q = 1'b0;
	logic seen = 1'b0;
	logic [63:0] q_data[$];
	logic [28:0] q_id[$];
	int q_launch[$];

	// Idle command lines carry the inverse of the last command, never a stale copy.
	initial begin
		frame_ready_o = 1'b0;
		cmd_valid_o = 1'b0;
		cmd_node_o = 4'hF;
		cmd_flags_o = 5'h1F;
	end

	// Launches are stamped when valid first shows; ready comes after the stall.
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		valid_q <= frame_valid_i;
		if (frame_valid_i && !valid_q) begin
			q_launch.push_back(cyc);
		end
		if (frame_valid_i && frame_ready_o) begin
			q_data.push_back(frame_data_i);
			q_id.push_back(frame_id_i);
			seen <= 1'b1;
			frame_ready_o <= 1'b0;
			wait_cnt <= 0;
		end else if (frame_valid_i) begin
			frame_ready_o <= (wait_cnt >= ready_wait);
			wait_cnt <= wait_cnt + 1;
		end
	end

	// A node only asks for power once a controller has shown itself on the bus.
	task automatic send(input logic [3:0] n, input logic [4:0] f);
		if (seen) begin
			@(posedge clk_i);
			cmd_valid_o <= 1'b1;
			cmd_node_o <= n;
			cmd_flags_o <= f;
			@(posedge clk_i);
			cmd_valid_o <= 1'b0;
			cmd_node_o <= ~n;
			cmd_flags_o <= ~f;
		end
	endtask : send
endmodule : gdsr_node_model

// *** gdsr_top_tb.sv ***
// Self-checking bench of the demand status reporter against a network node model.
// Assumes shortened timing: 10 cycles a millisecond, 5 ms a minute.
`timescale 1ns/1ps
module gdsr_top_tb;
	// ==========================================================================
	// Signals and model state
	// ==========================================================================
	localparam int MS = 10;
	localparam int HOLD_CYC = 2 * 5 * MS;
	logic clk_i;
	logic rst_i;
	logic [7:0] wb_adr_i;
	logic [31:0] wb_dat_i;
	logic [3:0] wb_sel_i;
	logic wb_we_i;
	logic wb_cyc_i;
	logic wb_stb_i;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic cmd_valid;
	logic [3:0] cmd_node;
	logic [4:0] cmd_flags;
	logic ext_activity_i;
	logic gen_fault_i;
	logic gen_run_o;
	logic frame_valid_o;
	logic frame_ready;
	logic [28:0] frame_id_o;
	logic [63:0] frame_data_o;
	logic irq_o;
	logic [31:0] rd_q;
	logic [31:0] qword = 32'h0;
	logic [7:0] minrun = 8'h0;
	int failures = 0;
	int num_checks = 0;
	int seed = 32'h3089;
	int list = 0, intd = 0, quiet = 0, ext = 0, man = 0, mdem = 0, qov = 0, lock = 0;
	int n_node = 0;
	int last_launch = 0;

	gdsr_top #(.CYC_PER_MS(MS), .MS_PER_MIN(5)) dut (.clk_i, .rst_i, .wb_adr_i, .wb_dat_i,
		.wb_sel_i, .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o,
		.cmd_valid_i(cmd_valid), .cmd_node_i(cmd_node), .cmd_demand_i(cmd_flags[0]),
		.cmd_qt_ovr_i(cmd_flags[1]), .cmd_ext_reset_i(cmd_flags[2]),
		.cmd_manual_i(cmd_flags[3]), .cmd_lock_i(cmd_flags[4]), .ext_activity_i,
		.gen_fault_i, .gen_run_o, .frame_valid_o, .frame_ready_i(frame_ready),
		.frame_id_o, .frame_data_o, .irq_o);
	gdsr_node_model node (.clk_i, .frame_valid_i(frame_valid_o), .frame_data_i(frame_data_o),
		.frame_id_i(frame_id_o), .frame_ready_o(frame_ready), .cmd_valid_o(cmd_valid),
		.cmd_node_o(cmd_node), .cmd_flags_o(cmd_flags));

	// Free-running 50 MHz clock.
	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end

	// ==========================================================================
	// Tasks and expectations
	// ==========================================================================
	task automatic end_of_test();
		$display("Checks %0d, mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : end_of_test

	task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t %s: got %0h expected %0h", $time, what, got, exp);
		end
	endtask : chk

	// One classic cycle; the request stands until ack is sampled high.
	task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		wb_adr_i <= a;
		wb_we_i <= w;
		wb_dat_i <= d;
		wb_sel_i <= 4'hF;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 16);
		rd_q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		if (wb_ack_o !== 1'b1) begin
			$display("[ERR] %0t no acknowledge", $time);
			failures++;
			end_of_test();
		end
	endtask : wb

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string what);
		wb(a, 1'b0, 32'h0);
		chk(rd_q, e, what);
	endtask : rd_chk

	// Overall demand: manual wins over the rest, external stop and lock win over all.
	function automatic int ovr();
		return (man ? mdem : (intd | (list != 0))) & !ext & !lock;
	endfunction : ovr

	function automatic logic [63:0] exp_data();
		return {8'hFF, minrun, qword, 8'(lock * 64 + qov * 16 + quiet * 4 + man),
			8'(ext * 64 + (list != 0) * 16 + intd * 4 + ovr())};
	endfunction : exp_data

	// Flags are {lock, manual, external reset, quiet override, demand}.
	task automatic cmd(input logic [4:0] f);
		list = f[0] ? (1 << n_node) : 0;
		qov = f[1];
		ext = f[2] ? 0 : ext;
		man = f[3];
		mdem = f[0];
		lock = f[4];
		node.send(4'(n_node), f);
	endtask : cmd

	// Waits for the next frame and compares content, spacing and run state.
	task automatic settle(input string name, input int lo, input int hi);
		int n;
		int gap;
		n = 0;
		node.ready_wait = $random(seed) & 3;
		while (node.q_data.size() == 0 && n < 60000) begin
			@(posedge clk_i);
			n++;
		end
		if (node.q_data.size() == 0) begin
			$display("[ERR] %0t no status frame", $time);
			failures++;
			end_of_test();
		end
		gap = node.q_launch[0] - last_launch;
		last_launch = node.q_launch.pop_front();
		chk(node.q_data.pop_front(), exp_data(), "frame data");
		chk(node.q_id.pop_front(), {gdsr_pkg::PRIO_DEFAULT, 1'b0, gdsr_pkg::DGN_DEMAND_STATUS,
			gdsr_pkg::SRC_ADDR_RST}, "frame id");
		chk(gap >= lo && gap <= hi, 1, "frame spacing");
		chk(gen_run_o, ovr() && (!quiet || qov), "run");
		$display("test %s done", name);
	endtask : settle

	// ==========================================================================
	// Main sequence
	// ==========================================================================
	initial begin
		rst_i = 1'b1;
		wb_adr_i = 8'h0;
		wb_dat_i = 32'h0;
		wb_sel_i = 4'h0;
		wb_we_i = 1'b0;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		ext_activity_i = 1'b0;
		gen_fault_i = 1'b0;
		repeat (16) @(posedge clk_i);
		chk({gen_run_o, frame_valid_o, wb_ack_o, irq_o, frame_id_o}, 0, "reset outputs");
		rst_i <= 1'b0;
		last_launch = node.cyc;
		rd_chk(gdsr_pkg::ADR_SRC, 32'h41, "source address");
		wb(8'h24, 1'b1, 32'h1234_5678);
		rd_chk(8'h24, 32'h0, "unmapped");
		rd_chk(gdsr_pkg::ADR_IRQ_CLR, 32'h0, "clear register");
		wb(gdsr_pkg::ADR_QUIET, 1'b1, 32'hFFFF_FFFF);
		rd_chk(gdsr_pkg::ADR_QUIET, 32'h3B17_3B17, "quiet clamp");
		wb(gdsr_pkg::ADR_MINRUN, 1'b1, 32'hFF);
		rd_chk(gdsr_pkg::ADR_MINRUN, 32'hFA, "minimum run clamp");
		qword = 32'h1E16_0008;
		minrun = 8'h02;
		wb(gdsr_pkg::ADR_QUIET, 1'b1, qword);
		wb(gdsr_pkg::ADR_MINRUN, 1'b1, 32'(minrun));
		wb(gdsr_pkg::ADR_IRQ_EN, 1'b1, 32'h4);
		settle("first frame", 5000, 5040);
		rd_chk(gdsr_pkg::ADR_IRQ_STAT, 32'h1, "sent status");
		chk(irq_o, 0, "masked interrupt");
		n_node = $random(seed) & 15;
		cmd(5'h01);
		rd_chk(gdsr_pkg::ADR_LIST, 32'(1 << n_node), "node list");
		settle("network demand", 5000, 5040);
		wb(gdsr_pkg::ADR_CTRL, 1'b1, 32'h1);
		intd = 1;
		cmd(5'h00);
		settle("internal demand", 5000, 5040);
		wb(gdsr_pkg::ADR_CTRL, 1'b1, 32'h3);
		quiet = 1;
		repeat (HOLD_CYC + 4) @(posedge clk_i);
		chk(gen_run_o, 0, "quiet stop");
		cmd(5'h02);
		settle("quiet override", 5000, 5040);
		@(posedge clk_i);
		ext_activity_i <= 1'b1;
		@(posedge clk_i);
		ext_activity_i <= 1'b0;
		ext = 1;
		repeat (2) @(posedge clk_i);
		chk(irq_o, 1, "external interrupt");
		wb(gdsr_pkg::ADR_IRQ_CLR, 1'b1, 32'h4);
		repeat (2) @(posedge clk_i);
		chk(irq_o, 0, "interrupt cleared");
		settle("external stop", 5000, 5040);
		cmd(5'h14);
		settle("reset and lock", 5000, 5040);
		wb(gdsr_pkg::ADR_CTRL, 1'b1, 32'h0);
		intd = 0;
		quiet = 0;
		cmd(5'h09);
		repeat (4) @(posedge clk_i);
		chk(gen_run_o, 1, "manual run");
		rd_chk(gdsr_pkg::ADR_STATUS, 32'(16'(exp_data())) + 32'h0100_0000, "status");
		cmd(5'h08);
		repeat (4) @(posedge clk_i);
		chk(gen_run_o, 1, "minimum run hold");
		repeat (HOLD_CYC + 4) @(posedge clk_i);
		chk(gen_run_o, 0, "minimum run expired");
		gen_fault_i <= 1'b1;
		ext = 1;
		settle("manual and fault", 5000, 5040);
		wb(gdsr_pkg::ADR_CTRL, 1'b1, 32'h4);
		gen_fault_i <= 1'b0;
		settle("steady repeat", 50000, 50040);
		ext = 0;
		settle("automatic clear", 5000, 5040);
		end_of_test();
	end
endmodule : gdsr_top_tb
